// *** rtl/lpic_defines.vh ***
/*
 * Constants for the LED PWM intensity block: register offsets, field
 * positions, reset values and PWM timing.
 * Assumes a 50 MHz system clock; included by bare name.
 */
`ifndef LPIC_DEFINES_VH
`define LPIC_DEFINES_VH

// register offsets
`define LPIC_ADDR_MASTER     8'h0e
`define LPIC_ADDR_INT_A      8'h10
`define LPIC_ADDR_INT_B      8'h11
`define LPIC_ADDR_INT_C      8'h12
`define LPIC_ADDR_INT_D      8'h13

// reset values (all outputs static after reset)
`define LPIC_MASTER_RST      8'h00
`define LPIC_INT_RST         8'h00
`define LPIC_RDATA_RST       8'h00

// field layout
`define LPIC_MASTER_HI       7
`define LPIC_MASTER_LO       4
`define LPIC_NINTH_HI        3
`define LPIC_NINTH_LO        0
`define LPIC_NIB_STATIC      4'hf
`define LPIC_NIB_ZERO        4'h0
`define LPIC_NUM_OUT         9
`define LPIC_NINTH_IDX       8

// pwm timing
`define LPIC_CLK_NS          20
`define LPIC_STEP_NS         31250
`define LPIC_STEP_CYC        (`LPIC_STEP_NS / `LPIC_CLK_NS)
`define LPIC_DIV_W           11
`define LPIC_STEPS_PER_SLOT  4'hf
`define LPIC_SLOTS_PER_PER   4'he
`define LPIC_DIV_ZERO        11'h000
`define LPIC_CNT_ZERO        4'h0
`define LPIC_CNT_ONE         4'h1
`define LPIC_DIV_ONE         11'h001

`endif

// *** rtl/lpic_timebase.v ***
/*
 * PWM timebase: divides the system clock to the step rate and counts
 * 16 pwm cycles per timeslot and 15 timeslots per period.
 * Assumes a synchronised active-low reset and one clock.
 */
`timescale 1ns/10ps
`include "lpic_defines.vh"

module lpic_timebase (
	input  wire       sys_clk,
	input  wire       rst_n,
	output reg  [3:0] step_reg,
	output reg  [3:0] slot_reg
);
	localparam integer           STEP_CYC_M1 = `LPIC_STEP_CYC - 1;
	localparam [`LPIC_DIV_W-1:0] STEP_LAST   = STEP_CYC_M1[`LPIC_DIV_W-1:0];

	reg [`LPIC_DIV_W-1:0] div_reg;
	wire                  step_en;

	assign step_en = (div_reg == STEP_LAST);

	// step rate divider, one enable pulse per pwm cycle
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			div_reg <= `LPIC_DIV_ZERO;
		else if (step_en)
			div_reg <= `LPIC_DIV_ZERO;
		else
			div_reg <= div_reg + `LPIC_DIV_ONE;
	end

	// 16 cycles per timeslot, 15 timeslots make the 240-step period
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_reg <= `LPIC_CNT_ZERO;
			slot_reg <= `LPIC_CNT_ZERO;
		end else if (step_en) begin
			step_reg <= step_reg + `LPIC_CNT_ONE;
			if (step_reg == `LPIC_STEPS_PER_SLOT) begin
				if (slot_reg == `LPIC_SLOTS_PER_PER)
					slot_reg <= `LPIC_CNT_ZERO;
				else
					slot_reg <= slot_reg + `LPIC_CNT_ONE;
			end
		end
	end
endmodule

// *** rtl/lpic_top.v ***
/*
 * LED PWM intensity control: master, ninth-output and per-output
 * intensity registers, and open-drain drive for nine outputs.
 * Outputs are registered, so every pin changes one clock after its cause;
 * writes to unmapped offsets are dropped and reads of them return zero.
 *
 * Assumes the serial front end presents a simple register port on
 * sys_clk, and that blink-phase selection and the global select flag
 * come from same-clock logic.
 * Assumes phase_bits carries the blink phase in force, bit 8 for the
 * ninth output; blink sequencing lives outside this block.
 * Assumes LED loads with series resistors pull a released pin high,
 * so a pin whose enable is low sits at high impedance.
 * Assumes the host keeps to the static and pwm mixing rules itself.
 * Assumes rstn may come from anywhere: its release passes two
 * flip-flops and the rest of the block uses that copy.
 */
// Summary of operation
// - master upper nibble zero: all outputs static
// - PWM on, global clear: per-output intensity
// - global set: ninth-output nibble intensity for all
// - phase bit 0: low (n+1)/16 of each gated slot
// - phase bit 1: duty cycle inverted
// - setting 0xF: static level, no PWM
// - period 240 steps: 15 slots of 16
// - master gates 1 to 15 timeslots
// - full setting ignores master gating, static
// - ninth output nibble doubles as global intensity
`timescale 1ns/10ps
`include "lpic_defines.vh"

module lpic_top (
	input  wire       sys_clk,
	input  wire       rstn,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_reg,
	input  wire [8:0] phase_bits,
	input  wire       global_sel,
	output reg  [8:0] out_pin_reg,
	output reg  [8:0] out_oe_reg
);
	reg  [1:0] rst_sync_reg;
	wire       rst_n;
	reg  [7:0] master_and_ninth_intensity_reg;
	reg  [7:0] output_intensity_a_reg;
	reg  [7:0] output_intensity_b_reg;
	reg  [7:0] output_intensity_c_reg;
	reg  [7:0] output_intensity_d_reg;
	reg  [7:0] rdata_next;
	reg  [8:0] oe_next;
	wire [3:0] step;
	wire [3:0] slot;
	wire [3:0] master_nib;
	wire [3:0] ninth_nib;
	wire       pwm_on;
	wire       slot_gate;

	// packed per-output intensity, one nibble per output
	localparam integer NIB_W = `LPIC_NINTH_HI - `LPIC_NINTH_LO + 1;
	localparam integer SEL_W = `LPIC_NUM_OUT * NIB_W;
	reg  [SEL_W-1:0]   sel_nib_next;

	// loop indices for the two decode processes
	integer    i;
	integer    j;

	// per-output intensity nibble; even output in low nibble
	function [3:0] nib_of;
		input [31:0] idx;
		input [7:0]  a;
		input [7:0]  b;
		input [7:0]  c;
		input [7:0]  d;
		input [3:0]  ninth;
		reg   [7:0]  pair;
		begin
			pair = 8'h00;
			case (idx[3:1])
				3'h0: pair = a;
				3'h1: pair = b;
				3'h2: pair = c;
				3'h3: pair = d;
				default: pair = 8'h00;
			endcase
			// the ninth output has no pair register
			if (idx == `LPIC_NINTH_IDX)
				nib_of = ninth;
			else if (idx[0])
				nib_of = pair[7:4];
			else
				nib_of = pair[3:0];
		end
	endfunction

	// drive decision: 1 means pull low
	function pull_low;
		input       pwm;
		input       gate;
		input [3:0] n;
		input [3:0] stp;
		input       phase;
		reg         active;
		begin
			active = 1'b0;
			// static when pwm is off or the setting is full
			if (!pwm || n == `LPIC_NIB_STATIC)
				pull_low = ~phase;
			else begin
				active = gate && (stp <= n);
				pull_low = phase ? ~active : active;
			end
		end
	endfunction

	// reset release through two flip-flops
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	// synchronised reset for the rest of the block
	assign rst_n = rst_sync_reg[1];

	// pwm step and timeslot counters
	lpic_timebase u_timebase (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.step_reg (step),
		.slot_reg (slot)
	);

	// master and ninth-output fields, pwm enable and slot gate
	assign master_nib = master_and_ninth_intensity_reg[`LPIC_MASTER_HI:`LPIC_MASTER_LO];
	assign ninth_nib  = master_and_ninth_intensity_reg[`LPIC_NINTH_HI:`LPIC_NINTH_LO];
	assign pwm_on     = (master_nib != `LPIC_NIB_ZERO);
	assign slot_gate  = (slot < master_nib);

	// intensity register writes
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			master_and_ninth_intensity_reg <= `LPIC_MASTER_RST;
			output_intensity_a_reg         <= `LPIC_INT_RST;
			output_intensity_b_reg         <= `LPIC_INT_RST;
			output_intensity_c_reg         <= `LPIC_INT_RST;
			output_intensity_d_reg         <= `LPIC_INT_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`LPIC_ADDR_MASTER: master_and_ninth_intensity_reg <= reg_wdata;
				`LPIC_ADDR_INT_A:  output_intensity_a_reg <= reg_wdata;
				`LPIC_ADDR_INT_B:  output_intensity_b_reg <= reg_wdata;
				`LPIC_ADDR_INT_C:  output_intensity_c_reg <= reg_wdata;
				`LPIC_ADDR_INT_D:  output_intensity_d_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	always @* begin
		case (reg_addr)
			`LPIC_ADDR_MASTER: rdata_next = master_and_ninth_intensity_reg;
			`LPIC_ADDR_INT_A:  rdata_next = output_intensity_a_reg;
			`LPIC_ADDR_INT_B:  rdata_next = output_intensity_b_reg;
			`LPIC_ADDR_INT_C:  rdata_next = output_intensity_c_reg;
			`LPIC_ADDR_INT_D:  rdata_next = output_intensity_d_reg;
			default:           rdata_next = `LPIC_RDATA_RST;
		endcase
	end

	// read data register, holds until the next read
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata_reg <= `LPIC_RDATA_RST;
		else if (reg_rd)
			reg_rdata_reg <= rdata_next;
	end

	// per-output intensity; global uses the ninth nibble for all outputs
	always @* begin
		sel_nib_next = {SEL_W{1'b0}};
		for (j = 0; j < `LPIC_NUM_OUT; j = j + 1) begin
			if (global_sel)
				sel_nib_next[j*NIB_W +: NIB_W] = ninth_nib;
			else
				sel_nib_next[j*NIB_W +: NIB_W] = nib_of(j,
					output_intensity_a_reg,
					output_intensity_b_reg,
					output_intensity_c_reg,
					output_intensity_d_reg,
					ninth_nib);
		end
	end

	// output decode: 1 in oe_next pulls the pin low
	always @* begin
		oe_next = 9'h000;
		for (i = 0; i < `LPIC_NUM_OUT; i = i + 1) begin
			oe_next[i] = pull_low(pwm_on,
				slot_gate,
				sel_nib_next[i*NIB_W +: NIB_W],
				step,
				phase_bits[i]);
		end
	end

	// open-drain outputs: value always low, enable drives the pin
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_oe_reg  <= 9'h000;
			out_pin_reg <= 9'h000;
		end else begin
			out_oe_reg  <= oe_next;
			out_pin_reg <= 9'h000;
		end
	end
endmodule

// *** sim/lpic_monitor.sv ***
/* checker for the pwm intensity block.
   sees the top ports only; bound below. */
`timescale 1ns/10ps
module lpic_monitor (
	input wire       sys_clk,
	input wire       rstn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata_reg,
	input wire [8:0] phase_bits,
	input wire       global_sel,
	input wire [8:0] out_pin_reg,
	input wire [8:0] out_oe_reg
);
	localparam int STEP = 1562;
	reg  [7:0]  m_reg;
	reg  [7:0]  a_reg;
	reg  [2:0]  up_reg;
	reg  [15:0] run_reg;
	wire        ok = (up_reg == 3'h7);
	// register mirrors, settle count, low-drive run length
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			m_reg <= 8'h00;
			a_reg <= 8'h00;
			up_reg <= 3'h0;
			run_reg <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == 8'h0e) m_reg <= reg_wdata;
			if (reg_wr && reg_addr == 8'h10) a_reg <= reg_wdata;
			if (!ok) up_reg <= up_reg + 3'h1;
			run_reg <= out_oe_reg[0] ? run_reg + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_pin_stays_low: assert property (
		out_pin_reg == 9'h000) else $error("pin value not low");
	a_static_master: assert property (
		ok && $past(m_reg[7:4]) == 4'h0 |-> out_oe_reg == ~$past(phase_bits))
		else $error("static mode level wrong");
	a_full_nibble: assert property (
		ok && $past(a_reg[3:0]) == 4'hf && !$past(global_sel)
		|-> out_oe_reg[0] == ~$past(phase_bits[0])) else $error("full setting not static");
	a_global_full: assert property (
		ok && $past(global_sel) && $past(m_reg[3:0]) == 4'hf
		|-> out_oe_reg == ~$past(phase_bits)) else $error("global full not static");
	a_phase_invert: assert property (
		ok && !$past(global_sel) && $past(a_reg[3:0]) == $past(a_reg[7:4])
		&& $past(phase_bits[1:0]) == 2'b10 |-> out_oe_reg[1] != out_oe_reg[0])
		else $error("phase inversion wrong");
	a_global_same: assert property (
		ok && $past(global_sel) && $past(phase_bits) == 9'h000
		|-> out_oe_reg == 9'h000 || out_oe_reg == 9'h1ff) else $error("global mismatch");
	a_pulse_bound: assert property (
		ok && $fell(out_oe_reg[0]) && !$past(global_sel) && !$past(phase_bits[0])
		&& $past(m_reg[7:4]) != 4'h0 && $past(a_reg[3:0]) != 4'hf
		|-> run_reg <= ($past(a_reg[3:0]) + 1) * STEP) else $error("pulse too long");
	a_read_master: assert property (
		reg_rd && reg_addr == 8'h0e |=> reg_rdata_reg == $past(m_reg))
		else $error("master read wrong");
	c_static: cover property (ok && $past(m_reg[7:4]) == 4'h0);
	c_global: cover property (ok && global_sel && m_reg[3:0] == 4'hf);
	c_pulse: cover property ($fell(out_oe_reg[0]));
endmodule
bind lpic_top lpic_monitor u_lpic_monitor (.sys_clk(sys_clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_reg(reg_rdata_reg), .phase_bits(phase_bits), .global_sel(global_sel),
	.out_pin_reg(out_pin_reg), .out_oe_reg(out_oe_reg));

// *** sim/lpic_led_loads.sv ***
/* led loads with series resistors on the nine open-drain pins.
   assumes a pull-up path through each led. */
`timescale 1ns/10ps
module lpic_led_loads (
	input  wire [8:0] out_pin_reg,
	input  wire [8:0] out_oe_reg,
	output wire [8:0] led_on
);
	wire [8:0] pad_level;
	// released pad floats high; led lit while sunk low
	assign pad_level = (out_oe_reg & out_pin_reg) | ~out_oe_reg;
	assign led_on = ~pad_level;
endmodule

// *** sim/tb.sv ***
/* self-checking bench for the pwm intensity block.
   assumes 1562 clocks per step; drives the plain register port. */
`timescale 1ns/10ps
module tb;
	reg        sys_clk, rstn, reg_wr, reg_rd, global_sel;
	reg  [7:0] reg_addr, reg_wdata, d;
	reg  [8:0] phase_bits;
	wire [7:0] reg_rdata_reg;
	wire [8:0] out_pin_reg, out_oe_reg, led_on;
	int        miscompares, compares, n;
	lpic_top u_lpic_top (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_reg(reg_rdata_reg), .phase_bits(phase_bits),
		.global_sel(global_sel), .out_pin_reg(out_pin_reg), .out_oe_reg(out_oe_reg));
	lpic_led_loads u_lpic_led_loads (.out_pin_reg(out_pin_reg),
		.out_oe_reg(out_oe_reg), .led_on(led_on));
	// clock
	always #10 sys_clk = ~sys_clk;
	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata_reg;
	endtask
	// cycles that pin 0 holds one drive level
	task run(input lv, input int cap);
		n = 0;
		while (out_oe_reg[0] === lv && n < cap) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	task t_regs;
		wr(8'h0e, 8'h5a);
		rd(8'h0e);
		chk("master", d, 8'h5a);
		wr(8'h10, 8'h3f);
		rd(8'h10);
		chk("intensity a", d, 8'h3f);
		rd(8'h20);
		chk("unmapped", d, 8'h00);
	endtask
	task t_static;
		global_sel <= 1'b1;
		phase_bits <= 9'h0a5;
		wr(8'h0e, 8'h0f);
		repeat (3) @(posedge sys_clk);
		chk("static", out_oe_reg, 9'h15a);
		chk("leds", led_on, 9'h15a);
		chk("pin", out_pin_reg, 9'h000);
	endtask
	task t_pwm;
		global_sel <= 1'b0;
		phase_bits <= 9'h002;
		wr(8'h10, 8'h33);
		wr(8'h11, 8'h0f);
		wr(8'h0e, 8'h2f);
		run(1'b0, 100);
		run(1'b1, 8000);
		run(1'b0, 20000);
		chk("gap", n, 12 * 1562);
		chk("inverted", out_oe_reg[1], 1'b0);
		run(1'b1, 8000);
		chk("pulse", n, 4 * 1562);
		chk("inverted", out_oe_reg[1], 1'b1);
		chk("fixed", out_oe_reg[2], 1'b1);
		run(1'b0, 14 * 1562);
		chk("gated", n, 14 * 1562);
	endtask
	task t_global;
		global_sel <= 1'b1;
		phase_bits <= 9'h003;
		wr(8'h0e, 8'h1f);
		repeat (3) @(posedge sys_clk);
		chk("global", out_oe_reg, 9'h1fc);
		phase_bits <= 9'h000;
		wr(8'h0e, 8'hfe);
		repeat (3) @(posedge sys_clk);
		chk("global pwm", out_oe_reg, 9'h1ff);
		run(1'b1, 24000);
		run(1'b0, 8000);
		chk("global gap", n, 1562);
		chk("global all", out_oe_reg, 9'h1ff);
	endtask
	task wrap_up;
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// watchdog
	initial begin
		#1900000;
		miscompares++;
		wrap_up;
	end
	// main sequence
	initial begin
		{sys_clk, rstn, reg_wr, reg_rd, global_sel} = 5'h00;
		{reg_addr, reg_wdata, phase_bits} = 25'h0;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_regs;
		t_static;
		t_pwm;
		t_global;
		wrap_up;
	end
endmodule
